// File: rtl/acct_timer_pkg.sv
package acct_timer_pkg;
    // clock and microsecond tick
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int CYCLES_PER_US = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // ring numbering: rings 0-3 are system time, ring 4 is user time
    localparam logic [2:0] USER_RING = 3'h4;

    // register indices on the plain register port
    localparam logic [3:0] ADDR_TALLY_LO = 4'h0;
    localparam logic [3:0] ADDR_TALLY_HI = 4'h1;
    localparam logic [3:0] ADDR_SELECTOR = 4'h2;
    localparam logic [3:0] ADDR_TTR_LO = 4'h3;
    localparam logic [3:0] ADDR_TTR_HI = 4'h4;
    localparam logic [3:0] ADDR_DELTA = 4'h5;
    localparam logic [3:0] ADDR_EXEC_SEL = 4'h6;
    localparam logic [3:0] ADDR_EXEC_LO = 4'h7;
    localparam logic [3:0] ADDR_EXEC_HI = 4'h8;

    // reset values
    localparam logic [63:0] TALLY_RESET = 64'h0000_0000_0000_0000;
    localparam logic [3:0] SELECTOR_RESET = 4'h0;

    // event_selector codes
    localparam logic [3:0] SEL_DCACHE_MISS = 4'h0;
    localparam logic [3:0] SEL_XLAT_MISS = 4'h1;
    localparam logic [3:0] SEL_DCACHE_READ = 4'h2;
    localparam logic [3:0] SEL_VEC_ELEMS = 4'h3;
    localparam logic [3:0] SEL_SYS_CLOCK = 4'h4;
    localparam logic [3:0] SEL_ICACHE_MISS = 4'h5;
    localparam logic [3:0] SEL_FP_OPS = 4'h6;

    // demand events signalled by the core's microcode
    typedef enum logic [4:0] {
        OP_NONE,
        OP_SYNC,
        OP_PUSH_FRAME,
        OP_POP_FRAME,
        OP_PAGE_FAULT,
        OP_RTNC,
        OP_TTR_WRITE,
        OP_TTR_READ,
        OP_CTX_CHANGE,
        OP_TID_CHANGE,
        OP_STORE_CRS,
        OP_LOAD_CRS,
        OP_IDLE_TARGET,
        OP_WFORK,
        OP_ENTER_IDLE,
        OP_IDLE_INT,
        OP_IDLE_FORK,
        OP_BASE_INT
    } acct_op_t;
endpackage

// File: rtl/cpu_time_accounting_timers.sv
// The register offsets and the strobed register port are this design's own decisions.
module cpu_time_accounting_timers
#(
    parameter int NUM_CTX = 8,
    parameter int VLEN = 128,
    parameter int VL_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire acct_timer_pkg::acct_op_t op_code,
    input wire logic op_ring_cross,
    input wire logic op_fork_accepted,
    input wire logic [$clog2(NUM_CTX)-1:0] context_index,
    input wire logic [2:0] op_ring,
    input wire logic [63:0] scalar_reg_k,
    input wire logic [$clog2(NUM_CTX)-1:0] load_ctx,
    input wire logic load_user,
    input wire logic [63:0] pop_ttr,
    input wire logic [63:0] pop_tally,
    input wire logic [3:0] pop_selector,
    output logic push_valid,
    output logic [63:0] push_ttr,
    output logic [63:0] push_tally,
    output logic [3:0] push_selector,
    output logic ttr_rd_valid,
    output logic [63:0] ttr_rd_data,
    input wire logic dcache_miss,
    input wire logic xlat_miss,
    input wire logic dcache_read,
    input wire logic icache_miss,
    input wire logic vec_mem_op,
    input wire logic fp_scalar_op,
    input wire logic fp_vector_op,
    input wire logic fp_fused,
    input wire logic vec_masked,
    input wire logic [VL_W-1:0] vector_length,
    input wire logic [VLEN-1:0] vector_mask
);
    import acct_timer_pkg::*;
    localparam int CTX_W = $clog2(NUM_CTX);

    // elaboration checks
    if (NUM_CTX < 2 || (1 << CTX_W) != NUM_CTX) begin : g_bad_ctx
        $error("NUM_CTX must be a power of two, at least 2");
    end
    if ((1 << VL_W) <= VLEN) begin : g_bad_vl
        $error("VL_W too narrow to hold VLEN");
    end
    if (CYCLES_PER_US < 1 || CYCLES_PER_US > 255) begin : g_bad_tick
        $error("microsecond divider out of range");
    end
    if (VLEN < 1) begin : g_bad_vlen
        $error("VLEN must be at least 1");
    end
    if (CTX_W + 1 > 32) begin : g_bad_view
        $error("execution counter view index wider than the register port");
    end

    // microsecond tick divider
    logic [7:0] div_reg;
    logic us_tick;
    assign us_tick = (div_reg == 8'(CYCLES_PER_US - 1));
    always_ff @(posedge clk) begin
        if (srst || us_tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // per-event action decode
    logic upd_ctr; // fold delta into the current execution counter
    logic upd_ttr; // fold delta into the thread timer
    logic clr_delta;
    logic clr_ttr;
    logic do_push; // frame or context block receives timer and tally
    logic do_pop;
    logic wr_ttr;
    logic rd_ttr;
    logic ld_crs; // counter word arrives from a register set load
    always_comb begin
        upd_ctr = 1'b0;
        upd_ttr = 1'b0;
        clr_delta = 1'b0;
        clr_ttr = 1'b0;
        do_push = 1'b0;
        do_pop = 1'b0;
        wr_ttr = 1'b0;
        rd_ttr = 1'b0;
        ld_crs = 1'b0;
        unique case (op_code)
            OP_SYNC: begin
                upd_ctr = 1'b1;
                upd_ttr = 1'b1;
                clr_delta = 1'b1;
            end
            OP_PUSH_FRAME: begin
                if (op_ring_cross) begin
                    upd_ctr = 1'b1;
                    upd_ttr = 1'b1;
                    do_push = 1'b1;
                    clr_ttr = 1'b1;
                    clr_delta = 1'b1;
                end
            end
            OP_POP_FRAME, OP_RTNC: begin
                if (op_ring_cross) begin
                    do_pop = 1'b1;
                    upd_ctr = 1'b1;
                    clr_delta = 1'b1;
                end
            end
            OP_PAGE_FAULT: begin
                do_push = 1'b1;
                if (op_ring_cross) begin
                    upd_ctr = 1'b1;
                    clr_ttr = 1'b1;
                    clr_delta = 1'b1;
                end
            end
            OP_TTR_WRITE: begin
                wr_ttr = 1'b1;
                upd_ctr = 1'b1;
                clr_delta = 1'b1;
            end
            OP_TTR_READ: begin
                rd_ttr = 1'b1;
                upd_ttr = 1'b1;
                upd_ctr = 1'b1;
                clr_delta = 1'b1;
            end
            OP_CTX_CHANGE, OP_BASE_INT: begin
                upd_ctr = 1'b1;
                clr_delta = 1'b1;
            end
            OP_STORE_CRS, OP_LOAD_CRS: begin
                ld_crs = (op_code == OP_LOAD_CRS);
                upd_ctr = 1'b1;
                upd_ttr = 1'b1;
                clr_delta = 1'b1;
            end
            OP_IDLE_TARGET: begin
                upd_ctr = 1'b1;
                clr_delta = 1'b1;
                clr_ttr = op_fork_accepted;
            end
            OP_ENTER_IDLE: begin
                // delta left running; the next thread creation clears it
                upd_ctr = 1'b1;
            end
            OP_IDLE_INT: begin
                clr_delta = 1'b1;
            end
            OP_IDLE_FORK: begin
                clr_ttr = 1'b1;
                clr_delta = 1'b1;
            end
            OP_NONE, OP_TID_CHANGE, OP_WFORK: begin
                upd_ctr = 1'b0;
            end
            default: ; // codes past the list take no action
        endcase
    end

    // delta timer; a tick in the clearing cycle is kept, so no microsecond is lost
    logic [63:0] delta_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            delta_reg <= 64'h0000_0000_0000_0000;
        end else if (clr_delta) begin
            delta_reg <= {63'h0, us_tick};
        end else if (us_tick) begin
            delta_reg <= delta_reg + 64'h0000_0000_0000_0001;
        end
    end

    // thread timer
    logic [63:0] ttr_reg;
    logic [63:0] ttr_sum;
    assign ttr_sum = ttr_reg + delta_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            ttr_reg <= 64'h0000_0000_0000_0000;
        end else if (do_pop) begin
            ttr_reg <= pop_ttr;
        end else if (wr_ttr) begin
            ttr_reg <= scalar_reg_k;
        end else if (clr_ttr) begin
            ttr_reg <= 64'h0000_0000_0000_0000;
        end else if (upd_ttr) begin
            ttr_reg <= ttr_sum;
        end
    end

    // execution counters: one system and one user word per context
    logic [63:0] exec_mem [2*NUM_CTX];
    logic [CTX_W:0] cur_idx;
    logic [CTX_W:0] ld_idx;
    logic [63:0] ld_sum;
    assign cur_idx = {context_index, op_ring == USER_RING};
    assign ld_idx = {load_ctx, load_user};
    assign ld_sum = ((ld_idx == cur_idx) ? scalar_reg_k : exec_mem[cur_idx]) + delta_reg;
    // only demand events write, which is why a plain read can lag
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < 2 * NUM_CTX; i++) begin
                exec_mem[i] <= 64'h0000_0000_0000_0000;
            end
        end else begin
            if (ld_crs && ld_idx != cur_idx) begin
                exec_mem[ld_idx] <= scalar_reg_k;
            end
            if (upd_ctr) begin
                exec_mem[cur_idx] <= ld_crs ? ld_sum : exec_mem[cur_idx] + delta_reg;
            end
        end
    end

    // event tally and selector are kept below; declared here because the push reads them
    logic [63:0] tally_reg;
    logic [3:0] selector_reg;

    // frame push: valid pulses once, the pushed words hold until the next push
    always_ff @(posedge clk) begin
        if (srst) begin
            push_valid <= 1'b0;
            push_ttr <= 64'h0000_0000_0000_0000;
            push_tally <= 64'h0000_0000_0000_0000;
            push_selector <= 4'h0;
        end else begin
            push_valid <= do_push;
            if (do_push) begin
                push_ttr <= upd_ttr ? ttr_sum : ttr_reg;
                push_tally <= tally_reg;
                push_selector <= selector_reg;
            end
        end
    end

    // thread timer read result
    always_ff @(posedge clk) begin
        if (srst) begin
            ttr_rd_valid <= 1'b0;
            ttr_rd_data <= 64'h0000_0000_0000_0000;
        end else begin
            ttr_rd_valid <= rd_ttr;
            if (rd_ttr) begin
                ttr_rd_data <= ttr_sum;
            end
        end
    end

    // masked element count: set mask bits within the first vector_length positions
    logic [VLEN-1:0] mask_live;
    logic [VL_W-1:0] mask_cnt;
    for (genvar i = 0; i < VLEN; i++) begin : g_mask_live
        // a bit past the vector length never counts, whatever the mask holds
        assign mask_live[i] = vector_mask[i] && (i < int'(vector_length));
    end
    assign mask_cnt = VL_W'($countones(mask_live));

    // increment for the selected event
    logic [VL_W:0] elems;
    logic [63:0] tally_inc;
    assign elems = {1'b0, vec_masked ? mask_cnt : vector_length};
    always_comb begin
        tally_inc = 64'h0000_0000_0000_0000;
        unique case (selector_reg)
            SEL_DCACHE_MISS: tally_inc = {63'h0, dcache_miss};
            SEL_XLAT_MISS: tally_inc = {63'h0, xlat_miss};
            SEL_DCACHE_READ: tally_inc = {63'h0, dcache_read};
            SEL_SYS_CLOCK: tally_inc = 64'h0000_0000_0000_0001;
            SEL_ICACHE_MISS: tally_inc = {63'h0, icache_miss};
            SEL_VEC_ELEMS: begin
                if (vec_mem_op) begin
                    tally_inc = 64'(elems);
                end
            end
            SEL_FP_OPS: begin
                if (fp_vector_op) begin
                    tally_inc = fp_fused ? 64'({elems, 1'b0}) : 64'(elems);
                end else if (fp_scalar_op) begin
                    tally_inc = 64'h0000_0000_0000_0001;
                end
            end
            default: tally_inc = 64'h0000_0000_0000_0000; // reserved codes
        endcase
    end

    // event tally: restore and software write take precedence over counting
    always_ff @(posedge clk) begin
        if (srst) begin
            tally_reg <= TALLY_RESET;
        end else if (do_pop) begin
            tally_reg <= pop_tally;
        end else if (reg_wr && reg_addr == ADDR_TALLY_LO) begin
            tally_reg <= {tally_reg[63:32], reg_wdata};
        end else if (reg_wr && reg_addr == ADDR_TALLY_HI) begin
            tally_reg <= {reg_wdata, tally_reg[31:0]};
        end else begin
            tally_reg <= tally_reg + tally_inc;
        end
    end

    // event selector
    always_ff @(posedge clk) begin
        if (srst) begin
            selector_reg <= SELECTOR_RESET;
        end else if (do_pop) begin
            selector_reg <= pop_selector;
        end else if (reg_wr && reg_addr == ADDR_SELECTOR) begin
            selector_reg <= reg_wdata[3:0];
        end
    end

    // execution counter view index
    logic [CTX_W:0] exec_sel_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            exec_sel_reg <= '0;
        end else if (reg_wr && reg_addr == ADDR_EXEC_SEL) begin
            exec_sel_reg <= reg_wdata[CTX_W:0];
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_TALLY_LO: reg_rdata <= tally_reg[31:0];
                ADDR_TALLY_HI: reg_rdata <= tally_reg[63:32];
                ADDR_SELECTOR: reg_rdata <= {28'h0, selector_reg};
                ADDR_TTR_LO: reg_rdata <= ttr_reg[31:0];
                ADDR_TTR_HI: reg_rdata <= ttr_reg[63:32];
                ADDR_DELTA: reg_rdata <= delta_reg[31:0];
                ADDR_EXEC_SEL: reg_rdata <= 32'(exec_sel_reg);
                ADDR_EXEC_LO: reg_rdata <= exec_mem[exec_sel_reg][31:0];
                ADDR_EXEC_HI: reg_rdata <= exec_mem[exec_sel_reg][63:32];
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // cpu_time_accounting_timers

// File: verification/acct_timer_sva.sv
module acct_timer_sva
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire acct_timer_pkg::acct_op_t op_code,
    input wire logic op_ring_cross,
    input wire logic [63:0] scalar_reg_k,
    input wire logic push_valid,
    input wire logic [63:0] push_ttr,
    input wire logic ttr_rd_valid,
    input wire logic [63:0] ttr_rd_data
);
    import acct_timer_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // a frame is owed by a crossing push and by every page fault
    logic push_ev;
    assign push_ev = (op_code == OP_PUSH_FRAME && op_ring_cross) || op_code == OP_PAGE_FAULT;

    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside answer cycle");
    AST_SEL_WIDTH: assert property (reg_rd && reg_addr == ADDR_SELECTOR |=> reg_rdata[31:4] == 28'h000_0000)
        else $error("selector wider than four bits");
    AST_PUSH_DUE: assert property (push_ev |=> push_valid)
        else $error("frame push missing");
    AST_PUSH_SPUR: assert property (!push_ev |=> !push_valid)
        else $error("frame push without cause");
    AST_PUSH_HOLD: assert property (!push_valid |-> $stable(push_ttr))
        else $error("pushed timer moved between pushes");
    AST_RD_DUE: assert property (op_code == OP_TTR_READ |=> ttr_rd_valid)
        else $error("timer read answer missing");
    AST_RD_SPUR: assert property (op_code != OP_TTR_READ |=> !ttr_rd_valid)
        else $error("timer read answer without read");
    // with one idle cycle between, at most one tick can fall in
    AST_INNER_CLR: assert property ((op_code == OP_PUSH_FRAME && op_ring_cross) ##1 op_code == OP_NONE
        ##1 op_code == OP_TTR_READ |=> ttr_rd_data <= 64'h1)
        else $error("timer not cleared on inner entry");
    AST_WRITE_CLR: assert property (op_code == OP_TTR_WRITE ##1 op_code == OP_NONE ##1 op_code == OP_TTR_READ
        |=> ttr_rd_data - $past(scalar_reg_k, 3) <= 64'h1)
        else $error("written timer value lost");
    AST_FORK_CLR: assert property (op_code == OP_IDLE_FORK ##1 op_code == OP_NONE ##1 op_code == OP_TTR_READ
        |=> ttr_rd_data <= 64'h1)
        else $error("timer not cleared on fork");
    AST_READ_STEP: assert property (op_code == OP_TTR_READ ##1 op_code == OP_NONE ##1 op_code == OP_TTR_READ
        |=> ttr_rd_data - $past(ttr_rd_data) <= 64'h1)
        else $error("timer jumped between reads");
endmodule // acct_timer_sva

// File: verification/frame_stack_model.sv
module frame_stack_model
(
    input wire logic clk,
    input wire logic srst,
    input wire acct_timer_pkg::acct_op_t op_code,
    input wire logic op_ring_cross,
    input wire logic push_valid,
    input wire logic [63:0] push_ttr,
    input wire logic [63:0] push_tally,
    input wire logic [3:0] push_selector,
    output logic [63:0] pop_ttr,
    output logic [63:0] pop_tally,
    output logic [3:0] pop_selector
);
    import acct_timer_pkg::*;
    logic [131:0] stack[$];
    logic [131:0] top = '0;
    // frames and context blocks share one stack; empty stack shows churn, not a stale frame
    always @(posedge clk) begin
        if (srst) begin
            stack.delete();
        end else begin
            if ((op_code == OP_POP_FRAME || op_code == OP_RTNC) && op_ring_cross && stack.size() > 0) begin
                void'(stack.pop_front());
            end
            if (push_valid) begin
                stack.push_front({push_ttr, push_tally, push_selector});
            end
        end
        top = (stack.size() > 0) ? stack[0] : ~top;
        {pop_ttr, pop_tally, pop_selector} <= top;
    end
endmodule // frame_stack_model

// File: verification/cpu_time_accounting_timers_tb_top.sv
module cpu_time_accounting_timers_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import acct_timer_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    acct_op_t op_code = OP_NONE;
    logic op_ring_cross = 1'b0;
    logic op_fork_accepted = 1'b0;
    logic load_user = 1'b0;
    logic [2:0] context_index = 3'h0;
    logic [2:0] op_ring = 3'h0;
    logic [2:0] load_ctx = 3'h0;
    logic [63:0] scalar_reg_k = '0;
    logic [63:0] pop_ttr, pop_tally, push_ttr, push_tally, ttr_rd_data, k;
    logic [3:0] pop_selector, push_selector;
    logic push_valid, ttr_rd_valid;
    logic [8:0] ev = 9'h000;
    logic [7:0] vector_length = 8'h00;
    logic [127:0] vector_mask = '0;
    longint unsigned thread_time_counter, delta, tally, rd_exp, exp_ttr, exp_push, exp_ptl, execs[16];
    int unsigned div, sel, view, exp_psel, failures = 0, total_checks = 0, cycles = 0;
    bit exp_rv, exp_pv;

    cpu_time_accounting_timers cpu_time_accounting_timers_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_code(op_code),
        .op_ring_cross(op_ring_cross), .op_fork_accepted(op_fork_accepted), .context_index(context_index),
        .op_ring(op_ring), .scalar_reg_k(scalar_reg_k), .load_ctx(load_ctx), .load_user(load_user),
        .pop_ttr(pop_ttr), .pop_tally(pop_tally), .pop_selector(pop_selector), .push_valid(push_valid),
        .push_ttr(push_ttr), .push_tally(push_tally), .push_selector(push_selector), .ttr_rd_valid(ttr_rd_valid),
        .ttr_rd_data(ttr_rd_data), .dcache_miss(ev[0]), .xlat_miss(ev[1]), .dcache_read(ev[2]),
        .icache_miss(ev[3]), .vec_mem_op(ev[4]), .fp_scalar_op(ev[5]), .fp_vector_op(ev[6]), .fp_fused(ev[7]),
        .vec_masked(ev[8]), .vector_length(vector_length), .vector_mask(vector_mask));
    frame_stack_model frame_stack_model_inst (.clk(clk), .srst(srst), .op_code(op_code),
        .op_ring_cross(op_ring_cross), .push_valid(push_valid), .push_ttr(push_ttr), .push_tally(push_tally),
        .push_selector(push_selector), .pop_ttr(pop_ttr), .pop_tally(pop_tally), .pop_selector(pop_selector));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic check(logic [63:0] seen, logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (failures == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one request cycle, then strobes drop; qualifiers are random every time
    task automatic cyc(acct_op_t op, bit wr, bit rdn, logic [3:0] a, logic [63:0] d);
        @(posedge clk);
        op_code <= op;
        op_ring_cross <= 1'($urandom);
        op_fork_accepted <= 1'($urandom);
        context_index <= 3'($urandom);
        op_ring <= 3'($urandom_range(0, 4));
        load_ctx <= 3'($urandom);
        load_user <= 1'($urandom);
        scalar_reg_k <= d;
        reg_wr <= wr;
        reg_rd <= rdn;
        reg_addr <= a;
        reg_wdata <= d[31:0];
        @(posedge clk);
        op_code <= OP_NONE;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    // background event traffic; scalar and vector float never share a cycle
    always @(posedge clk) begin
        logic [8:0] e;
        e = 9'($urandom);
        ev <= srst ? 9'h000 : {e[8:7], e[6] & ~e[5], e[5:0]};
        vector_length <= 8'($urandom_range(0, 128));
        vector_mask <= {$urandom, $urandom, $urandom, $urandom};
    end

    // reference model: judges what the last edge produced, then steps
    always @(posedge clk) begin
        longint unsigned d, rd, n, inc;
        bit tick, ue, cl, popx;
        int unsigned idx;
        cycles++;
        if (cycles > 40000) begin
            failures++;
            complete_run();
        end
        if (!srst) begin
            check(reg_rdata, rd_exp);
            check(ttr_rd_valid, exp_rv);
            check(push_valid, exp_pv);
            if (exp_rv) check(ttr_rd_data, exp_ttr);
            if (exp_pv) check(push_ttr, exp_push);
            if (exp_pv) check(push_tally, exp_ptl);
            if (exp_pv) check(push_selector, exp_psel);
        end
        if (srst) begin
            {thread_time_counter, delta, tally, sel, view, div, rd_exp, exp_rv, exp_pv} = '0;
            execs = '{default: 0};
        end else begin
            tick = (div == CYCLES_PER_US - 1);
            d = delta;
            {ue, cl, popx, exp_rv, exp_pv, n} = '0;
            case (reg_addr)
                ADDR_TALLY_LO, ADDR_TTR_LO, ADDR_DELTA, ADDR_EXEC_LO: rd = reg_addr == ADDR_TALLY_LO ? tally :
                    reg_addr == ADDR_TTR_LO ? thread_time_counter : reg_addr == ADDR_DELTA ? delta : execs[view];
                ADDR_TALLY_HI: rd = tally >> 32;
                ADDR_TTR_HI: rd = thread_time_counter >> 32;
                ADDR_EXEC_HI: rd = execs[view] >> 32;
                ADDR_SELECTOR: rd = sel;
                ADDR_EXEC_SEL: rd = view;
                default: rd = 0;
            endcase
            rd_exp = reg_rd ? rd & 32'hFFFF_FFFF : 0;
            for (int i = 0; i < vector_length; i++) n += ev[8] ? vector_mask[i] : 1;
            case (sel)
                0, 1, 2: inc = ev[sel];
                3: inc = ev[4] ? n : 0;
                4: inc = 1;
                5: inc = ev[3];
                6: inc = ev[5] + (ev[6] ? n * (ev[7] ? 2 : 1) : 0);
                default: inc = 0;
            endcase
            idx = {context_index, op_ring == USER_RING};
            case (op_code)
                OP_SYNC, OP_STORE_CRS, OP_TTR_READ: begin
                    thread_time_counter += d;
                    exp_ttr = thread_time_counter;
                    exp_rv = op_code == OP_TTR_READ;
                    {ue, cl} = 2'b11;
                end
                OP_LOAD_CRS: begin
                    execs[{load_ctx, load_user}] = scalar_reg_k;
                    thread_time_counter += d;
                    {ue, cl} = 2'b11;
                end
                OP_TTR_WRITE: begin
                    thread_time_counter = scalar_reg_k;
                    {ue, cl} = 2'b11;
                end
                OP_PUSH_FRAME, OP_PAGE_FAULT: begin
                    exp_pv = op_code == OP_PAGE_FAULT || op_ring_cross;
                    if (op_code == OP_PUSH_FRAME && op_ring_cross) thread_time_counter += d;
                    exp_push = thread_time_counter;
                    {exp_ptl, exp_psel} = {tally, sel};
                    if (op_ring_cross) {thread_time_counter, ue, cl} = {64'h0, 2'b11};
                end
                OP_POP_FRAME, OP_RTNC: if (op_ring_cross) begin
                    {thread_time_counter, tally, sel, ue, cl, popx} = {pop_ttr, pop_tally, 28'h0, pop_selector, 3'b111};
                end
                OP_CTX_CHANGE, OP_BASE_INT, OP_IDLE_TARGET: begin
                    {ue, cl} = 2'b11;
                    if (op_code == OP_IDLE_TARGET && op_fork_accepted) thread_time_counter = 0;
                end
                OP_ENTER_IDLE: ue = 1;
                OP_IDLE_INT: cl = 1;
                OP_IDLE_FORK: {thread_time_counter, cl} = {64'h0, 1'b1};
                default: ;
            endcase
            if (ue) execs[idx] += d;
            // a crossing pop beats both software writes and counting
            if (popx) ;
            else if (reg_wr && reg_addr == ADDR_TALLY_LO) tally = {tally[63:32], reg_wdata};
            else if (reg_wr && reg_addr == ADDR_TALLY_HI) tally = {reg_wdata, tally[31:0]};
            else tally += inc;
            if (!popx && reg_wr && reg_addr == ADDR_SELECTOR) sel = reg_wdata[3:0];
            if (reg_wr && reg_addr == ADDR_EXEC_SEL) view = reg_wdata[3:0];
            delta = cl ? tick : delta + tick;
            div = tick ? 0 : div + 1;
        end
    end

    initial begin
        void'($urandom(34484));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 16; i++) cyc(OP_NONE, 0, 1, 4'(i), '0);
            for (int i = 0; i < 3000; i++) begin
                k = ($urandom_range(0, 3) == 0) ? '1 : {$urandom, $urandom};
                case ($urandom_range(0, 5))
                    0: cyc(acct_op_t'($urandom_range(1, 17)), 0, 0, 4'h0, k);
                    1: cyc(OP_TTR_READ, 0, 0, 4'h0, k);
                    2: cyc(OP_NONE, 0, 1, 4'($urandom), k);
                    3: cyc(OP_NONE, 1, 0, 4'($urandom), k);
                    4: repeat ($urandom_range(0, 40)) @(posedge clk);
                    default: cyc(OP_NONE, 1, 0, ADDR_SELECTOR, 64'(i % 16));
                endcase
            end
            // reset again after each of the two passes, mid-run after the first
            srst <= 1'b1;
            repeat (4) @(posedge clk);
            srst <= 1'b0;
        end
        complete_run();
    end
endmodule // cpu_time_accounting_timers_tb_top

bind cpu_time_accounting_timers acct_timer_sva acct_timer_sva_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_code(op_code), .op_ring_cross(op_ring_cross),
    .scalar_reg_k(scalar_reg_k), .push_valid(push_valid), .push_ttr(push_ttr), .ttr_rd_valid(ttr_rd_valid),
    .ttr_rd_data(ttr_rd_data));
